// [src/osc_ctl_pkg.sv]
// constants, types and register layout of the oscillator source select block
package osc_ctl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STARTUP_OSCILLATIONS = 1024;
  localparam logic [9:0] STARTUP_LAST = 10'(STARTUP_OSCILLATIONS - 1);
  // settle times of the high oscillator model; least times round up
  localparam int HF_READY_NS = 2000;
  localparam int HF_LOCK_NS = 8000;
  localparam int HF_STABLE_NS = 16000;
  localparam logic [8:0] HF_READY_CYC = 9'((HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] HF_LOCK_CYC = 9'((HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] HF_STABLE_CYC = 9'((HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // oscillator frequencies
  // ----------------------------------------------------------------
  localparam int MF_FREQ_KHZ = 500;
  localparam int HF_FREQ_KHZ = 16000;
  localparam int LF_FREQ_KHZ = 31;
  localparam int HF_PLL_MULT = HF_FREQ_KHZ / MF_FREQ_KHZ;
  localparam int EXT_PLL_MULT = 4;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OSC_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] OSC_STATUS_OFFSET = 4'h4;
  localparam logic [3:0] OSC_TUNING_OFFSET = 4'h8;
  localparam logic [7:0] OSC_CONTROL_RESET = 8'h38;
  localparam logic [5:0] OSC_TUNING_RESET = 6'h00;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  localparam int FREQ_LSB = 3;
  localparam int FREQ_MSB = 6;
  localparam int SW_PLL_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_WATCH_XTAL = 3'h0;
  localparam logic [2:0] MODE_MID_XTAL = 3'h1;
  localparam logic [2:0] MODE_HIGH_XTAL = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;
  localparam logic [2:0] MODE_OUT_LOW = 3'h5;
  localparam logic [2:0] MODE_OUT_MID = 3'h6;
  localparam logic [2:0] MODE_OUT_HIGH = 3'h7;
  localparam logic [1:0] SEL_CONFIGURED = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [3:0] FREQ_HF_MIN = 4'h9;
  localparam logic [3:0] FREQ_HF_TOP = 4'hF;
  localparam logic [3:0] FREQ_PLL32 = 4'hE;
  localparam logic [3:0] FREQ_LF_MAX = 4'h1;
  localparam logic [1:0] LEVEL_OFF = 2'h0;
  localparam logic [1:0] LEVEL_LOW = 2'h1;
  localparam logic [1:0] LEVEL_MID = 2'h2;
  localparam logic [1:0] LEVEL_HIGH = 2'h3;

  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} src_type;
  typedef enum logic [1:0] {SEQ_WAIT_POWERUP, SEQ_COUNT, SEQ_RUN} seq_type;

  typedef struct packed {
    logic [2:0] clockSource;
    logic pllEnable;
    logic clockOutPinCfg;
    logic failSafeEn;
    logic twoSpeedEn;
    logic powerupDelayEn;
  } cfg_type;

  typedef struct packed {
    logic cpuRun;
    src_type clkSource;
    logic pllMuxSel;
    logic hfOscEnable;
    logic lfOscEnable;
    logic [1:0] ampGain;
    logic [1:0] ecPower;
    logic oscInGpio;
    logic oscOutClkOut;
    logic [3:0] postShift;
    logic [5:0] tune;
    logic hfReady;
    logic hfLocked;
    logic hfStable;
    logic startupStatus;
  } ctl_type;

endpackage : osc_ctl_pkg

// [src/oscillator_source_select.sv]
// oscillator source select, start-up timer and register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module oscillator_source_select (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [osc_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [osc_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire osc_ctl_pkg::cfg_type cfgWord,
  input wire logic powerupDone,
  input wire logic wakeFromSleep,
  input wire logic oscInputPin,
  output osc_ctl_pkg::ctl_type ctlOut
);
  import osc_ctl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awTaken;
    logic [ADDR_W-1:0] awAddr;
    logic wTaken;
    logic [7:0] wData;
    logic wLane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] control;
    logic [5:0] tuning;
    seq_type seq;
    logic [9:0] startupCnt;
    logic [1:0] pinSync;
    logic pinPrev;
    logic [8:0] hfCnt;
    ctl_type ctl;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready = state_ff.wready;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;
  assign ctlOut = state_ff.ctl;

  always_comb begin
    logic crystal;
    logic outsideClk;
    logic pinEdge;
    logic autoInternal;
    logic [1:0] clkSel;
    logic [3:0] freqSel;
    logic hfSel;
    logic pllOn;
    logic [3:0] statusBits;
    crystal = 1'b0;
    outsideClk = 1'b0;
    pinEdge = 1'b0;
    autoInternal = 1'b0;
    clkSel = 2'h0;
    freqSel = 4'h0;
    hfSel = 1'b0;
    pllOn = 1'b0;
    statusBits = 4'h0;
    nxt_state = state_ff;

    // ----------------------------------------------------------------
    // pin synchroniser and edge detect
    // ----------------------------------------------------------------
    nxt_state.pinSync = {state_ff.pinSync[0], oscInputPin};
    nxt_state.pinPrev = state_ff.pinSync[1];
    pinEdge = state_ff.pinSync[1] && !state_ff.pinPrev;

    crystal = (cfgWord.clockSource == MODE_WATCH_XTAL) ||
              (cfgWord.clockSource == MODE_MID_XTAL) ||
              (cfgWord.clockSource == MODE_HIGH_XTAL);
    outsideClk = (cfgWord.clockSource == MODE_OUT_LOW) ||
                 (cfgWord.clockSource == MODE_OUT_MID) ||
                 (cfgWord.clockSource == MODE_OUT_HIGH);

    // ----------------------------------------------------------------
    // start-up sequence
    // ----------------------------------------------------------------
    case (state_ff.seq)
      SEQ_WAIT_POWERUP: begin
        if (!cfgWord.powerupDelayEn || powerupDone) begin
          nxt_state.startupCnt = '0;
          nxt_state.seq = crystal ? SEQ_COUNT : SEQ_RUN;
        end
      end
      SEQ_COUNT: begin
        if (pinEdge) begin
          nxt_state.startupCnt = state_ff.startupCnt + 10'h001;
          if (state_ff.startupCnt == STARTUP_LAST) begin
            nxt_state.seq = SEQ_RUN;
          end
        end
      end
      SEQ_RUN: begin
        // wake restarts the count only for crystals; other modes resume at once
        if (wakeFromSleep && crystal) begin
          nxt_state.startupCnt = '0;
          nxt_state.seq = SEQ_COUNT;
        end
      end
      default: begin
        nxt_state.seq = SEQ_WAIT_POWERUP;
      end
    endcase

    // ----------------------------------------------------------------
    // register slave: write
    // ----------------------------------------------------------------
    if (s_axi_awvalid && state_ff.awready) begin
      nxt_state.awTaken = 1'b1;
      nxt_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready) begin
      nxt_state.wTaken = 1'b1;
      nxt_state.wData = s_axi_wdata[7:0];
      nxt_state.wLane0 = s_axi_wstrb[0];
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.awTaken && state_ff.wTaken && !state_ff.bvalid) begin
      nxt_state.awTaken = 1'b0;
      nxt_state.wTaken = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = RESP_OKAY;
      case (state_ff.awAddr)
        OSC_CONTROL_OFFSET: begin
          if (state_ff.wLane0) begin
            nxt_state.control = state_ff.wData;
          end
        end
        OSC_TUNING_OFFSET: begin
          if (state_ff.wLane0) begin
            nxt_state.tuning = state_ff.wData[5:0];
          end
        end
        OSC_STATUS_OFFSET: begin
          nxt_state.bresp = RESP_OKAY;
        end
        default: begin
          nxt_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_state.awready = !nxt_state.awTaken && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.wTaken && !nxt_state.bvalid;

    // ----------------------------------------------------------------
    // clock selection
    // ----------------------------------------------------------------
    clkSel = state_ff.control[SEL_MSB:SEL_LSB];
    freqSel = state_ff.control[FREQ_MSB:FREQ_LSB];
    hfSel = (freqSel >= FREQ_HF_MIN);
    // automatic switch while the crystal starts; clock select stays untouched
    autoInternal = crystal && (state_ff.seq != SEQ_RUN) &&
                   (cfgWord.failSafeEn || cfgWord.twoSpeedEn);
    pllOn = cfgWord.pllEnable || state_ff.control[SW_PLL_BIT];

    nxt_state.ctl.clkSource = SRC_PRIMARY;
    nxt_state.ctl.pllMuxSel = 1'b0;
    if (clkSel[1]) begin
      nxt_state.ctl.clkSource = SRC_INTERNAL;
    end else if (clkSel == SEL_SECONDARY) begin
      nxt_state.ctl.clkSource = SRC_SECONDARY;
    end else begin
      if (cfgWord.clockSource == MODE_INTERNAL || autoInternal) begin
        nxt_state.ctl.clkSource = SRC_INTERNAL;
      end
      // the pll is only in the path with the configured source
      nxt_state.ctl.pllMuxSel = pllOn &&
        (cfgWord.clockSource != MODE_INTERNAL || freqSel == FREQ_PLL32);
    end

    nxt_state.ctl.hfOscEnable = hfSel &&
      (cfgWord.clockSource == MODE_INTERNAL || clkSel[1]);
    nxt_state.ctl.lfOscEnable = (freqSel <= FREQ_LF_MAX) &&
      (cfgWord.clockSource == MODE_INTERNAL || clkSel[1]);
    // hf settings divide by powers of two; limitation: lower mf codes share shift 0
    nxt_state.ctl.postShift = hfSel ? (FREQ_HF_TOP - freqSel) : 4'h0;
    nxt_state.ctl.tune = state_ff.tuning;

    // ----------------------------------------------------------------
    // oscillator drive and pins
    // ----------------------------------------------------------------
    case (cfgWord.clockSource)
      MODE_WATCH_XTAL: nxt_state.ctl.ampGain = LEVEL_LOW;
      MODE_MID_XTAL: nxt_state.ctl.ampGain = LEVEL_MID;
      MODE_HIGH_XTAL: nxt_state.ctl.ampGain = LEVEL_HIGH;
      default: nxt_state.ctl.ampGain = LEVEL_OFF;
    endcase
    case (cfgWord.clockSource)
      MODE_OUT_LOW: nxt_state.ctl.ecPower = LEVEL_LOW;
      MODE_OUT_MID: nxt_state.ctl.ecPower = LEVEL_MID;
      MODE_OUT_HIGH: nxt_state.ctl.ecPower = LEVEL_HIGH;
      default: nxt_state.ctl.ecPower = LEVEL_OFF;
    endcase
    nxt_state.ctl.oscInGpio = (cfgWord.clockSource == MODE_INTERNAL);
    nxt_state.ctl.oscOutClkOut = cfgWord.clockOutPinCfg &&
      (outsideClk || cfgWord.clockSource == MODE_RC ||
       cfgWord.clockSource == MODE_INTERNAL);

    // ----------------------------------------------------------------
    // execution gate and status
    // ----------------------------------------------------------------
    nxt_state.ctl.cpuRun = (nxt_state.seq == SEQ_RUN) ||
      (nxt_state.seq == SEQ_COUNT && (cfgWord.failSafeEn || cfgWord.twoSpeedEn));
    nxt_state.ctl.startupStatus = !crystal || (nxt_state.seq == SEQ_RUN);

    // settle counter restarts from zero whenever the oscillator is shut down
    if (!nxt_state.ctl.hfOscEnable) begin
      nxt_state.hfCnt = '0;
    end else if (state_ff.hfCnt != HF_STABLE_CYC) begin
      nxt_state.hfCnt = state_ff.hfCnt + 9'h001;
    end
    nxt_state.ctl.hfReady = (nxt_state.hfCnt >= HF_READY_CYC);
    nxt_state.ctl.hfLocked = (nxt_state.hfCnt >= HF_LOCK_CYC);
    nxt_state.ctl.hfStable = (nxt_state.hfCnt >= HF_STABLE_CYC);

    // ----------------------------------------------------------------
    // register slave: read
    // ----------------------------------------------------------------
    statusBits = {state_ff.ctl.startupStatus, state_ff.ctl.hfStable,
                  state_ff.ctl.hfLocked, state_ff.ctl.hfReady};
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OSC_CONTROL_OFFSET: nxt_state.rdata = 32'(state_ff.control);
        OSC_STATUS_OFFSET: nxt_state.rdata = 32'(statusBits);
        OSC_TUNING_OFFSET: nxt_state.rdata = 32'(state_ff.tuning);
        default: begin
          nxt_state.rdata = '0;
          nxt_state.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_state.arready = !nxt_state.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // no enable other than the clock: with the clock halted only the asynchronous rst_n changes a bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
      state_ff.control <= OSC_CONTROL_RESET;
      state_ff.tuning <= OSC_TUNING_RESET;
      state_ff.seq <= SEQ_WAIT_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : oscillator_source_select

// [verification/osc_select_monitor.sv]
// assertion checker for the oscillator source select block
`timescale 1ns/1ps
module osc_select_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire osc_ctl_pkg::cfg_type cfgWord,
  input wire logic powerupDone,
  input wire osc_ctl_pkg::ctl_type ctlOut
);
  import osc_ctl_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence xtal_plain;
    cfgWord.clockSource <= MODE_HIGH_XTAL && !cfgWord.failSafeEn && !cfgWord.twoSpeedEn;
  endsequence
  rd_latency_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  ec_nodelay_a: assert property (cfgWord.clockSource >= MODE_OUT_LOW
    && (!cfgWord.powerupDelayEn || powerupDone) |-> ##[0:3] ctlOut.cpuRun)
    else $error("outside clock held");
  xtal_hold_a: assert property (xtal_plain ##0 !ctlOut.startupStatus |-> !ctlOut.cpuRun)
    else $error("execution during start-up count");
  xtal_gain_a: assert property (cfgWord.clockSource <= MODE_HIGH_XTAL
    |=> ctlOut.ampGain == cfgWord.clockSource[1:0] + 2'h1) else $error("wrong amplifier gain");
  hf_clear_a: assert property (!ctlOut.hfOscEnable
    |-> !(ctlOut.hfReady || ctlOut.hfLocked || ctlOut.hfStable)) else $error("status not cleared");
  hf_order_a: assert property (ctlOut.hfStable |-> ctlOut.hfLocked && ctlOut.hfReady)
    else $error("status bits out of order");
  hf_settle_a: assert property ($rose(ctlOut.hfOscEnable) |-> (!ctlOut.hfReady) [*8])
    else $error("ready too early");
endmodule : osc_select_monitor
bind oscillator_source_select osc_select_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .cfgWord(cfgWord),
  .powerupDone(powerupDone), .ctlOut(ctlOut));

// [verification/osc_pin_model.sv]
// behavioural crystal or outside clock on the oscillator input pin
`timescale 1ns/1ps
module osc_pin_model #(
  parameter int HALF_NS = 175
) (
  input wire logic pinRun,
  output logic oscInputPin
);
  // a stopped source rests low; half period is not a multiple of the system clock on purpose
  initial begin
    oscInputPin = 1'b0;
    forever begin
      #(HALF_NS);
      oscInputPin = pinRun ? ~oscInputPin : 1'b0;
    end
  end
endmodule : osc_pin_model

// [verification/testbench.sv]
// self-checking bench for the oscillator source select block
`timescale 1ns/1ps
module testbench;
  import osc_ctl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  cfg_type cfgWord = '0;
  logic powerupDone = 1'b0, wakeFromSleep = 1'b0, pinRun = 1'b0, oscInputPin;
  ctl_type ctlOut;
  int fails = 0, n_compared = 0, cycles = 0;
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  osc_pin_model pin (.pinRun(pinRun), .oscInputPin(oscInputPin));
  oscillator_source_select dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .cfgWord(cfgWord),
    .powerupDone(powerupDone), .wakeFromSleep(wakeFromSleep), .oscInputPin(oscInputPin),
    .ctlOut(ctlOut));
  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done();
    end
  end
  task automatic do_reset(input cfg_type c);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    cfgWord <= c;
    pinRun <= 1'b0;
    powerupDone <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : do_reset
  // each channel holds until the edge that takes it; the answer is taken at that same edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic awPend, wPend, bPend;
    awPend = 1'b1;
    wPend = 1'b1;
    bPend = 1'b1;
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    while (bPend) begin
      @(posedge clk_sys);
      if (awPend && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        awPend = 1'b0;
      end
      if (wPend && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wPend = 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        bPend = 1'b0;
      end
    end
    @(negedge clk_sys);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a);
    logic arPend, rPend;
    arPend = 1'b1;
    rPend = 1'b1;
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (rPend) begin
      @(posedge clk_sys);
      if (arPend && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        arPend = 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        rPend = 1'b0;
      end
    end
    @(negedge clk_sys);
  endtask : axi_read
  // one wait per rising edge: no race with a separate edge counter
  task automatic wait_edges(input int n);
    repeat (n) @(posedge oscInputPin);
    #1;
  endtask : wait_edges
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_outside_clock();
    cfg_type c;
    c = '0;
    c.clockSource = MODE_OUT_MID;
    c.clockOutPinCfg = 1'b1;
    do_reset(c);
    check("cpuRun", ctlOut.cpuRun, 1'b1);
    check("ecPower", ctlOut.ecPower, LEVEL_MID);
    check("oscOutClkOut", ctlOut.oscOutClkOut, 1'b1);
    check("clkSource", ctlOut.clkSource, SRC_PRIMARY);
    axi_read(OSC_CONTROL_OFFSET);
    check("control", rd, 32'h0000_0038);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_00B8);
    check("pllMuxSel", ctlOut.pllMuxSel, 1'b1);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_0039);
    check("clkSource", ctlOut.clkSource, SRC_SECONDARY);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_007A);
    check("clkSource", ctlOut.clkSource, SRC_INTERNAL);
    check("hfOscEnable", ctlOut.hfOscEnable, 1'b1);
    check("postShift", ctlOut.postShift, 4'h0);
    repeat (30) @(negedge clk_sys);
    check("hfReady", ctlOut.hfReady, 1'b0);
    repeat (300) @(negedge clk_sys);
    axi_read(OSC_STATUS_OFFSET);
    check("status", rd, 32'h0000_000F);
    axi_write(OSC_STATUS_OFFSET, 32'h0000_0000);
    check("bresp", rsp, RESP_OKAY);
    axi_read(OSC_STATUS_OFFSET);
    check("status", rd, 32'h0000_000F);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_0038);
    axi_read(OSC_STATUS_OFFSET);
    check("status", rd, 32'h0000_0008);
    axi_read(OSC_TUNING_OFFSET);
    check("tuning", rd, 32'h0000_0000);
    axi_write(OSC_TUNING_OFFSET, 32'hFFFF_FFFF);
    axi_read(OSC_TUNING_OFFSET);
    check("tuning", rd, 32'h0000_003F);
    check("tune", ctlOut.tune, 6'h3F);
    axi_read(4'hC);
    check("rresp", rsp, RESP_SLVERR);
    check("rdata", rd, 32'h0000_0000);
  endtask : t_outside_clock
  task automatic t_internal();
    cfg_type c;
    c = '0;
    c.clockSource = MODE_INTERNAL;
    c.pllEnable = 1'b1;
    do_reset(c);
    check("oscInGpio", ctlOut.oscInGpio, 1'b1);
    check("hfOscEnable", ctlOut.hfOscEnable, 1'b0);
    check("pllMuxSel", ctlOut.pllMuxSel, 1'b0);
    check("clkSource", ctlOut.clkSource, SRC_INTERNAL);
    check("lfOscEnable", ctlOut.lfOscEnable, 1'b0);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_0070);
    check("pllMuxSel", ctlOut.pllMuxSel, 1'b1);
    check("hfOscEnable", ctlOut.hfOscEnable, 1'b1);
    check("postShift", ctlOut.postShift, 4'h1);
    axi_write(OSC_CONTROL_OFFSET, 32'h0000_0008);
    check("lfOscEnable", ctlOut.lfOscEnable, 1'b1);
    check("hfOscEnable", ctlOut.hfOscEnable, 1'b0);
    check("pllMuxSel", ctlOut.pllMuxSel, 1'b0);
  endtask : t_internal
  task automatic t_failsafe();
    cfg_type c;
    for (int i = 0; i < 2; i++) begin
      c = '0;
      c.clockSource = (i == 0) ? MODE_WATCH_XTAL : MODE_MID_XTAL;
      c.twoSpeedEn = (i == 0);
      c.failSafeEn = (i == 1);
      do_reset(c);
      check("cpuRun", ctlOut.cpuRun, 1'b1);
      check("clkSource", ctlOut.clkSource, SRC_INTERNAL);
      check("ampGain", ctlOut.ampGain, (i == 0) ? LEVEL_LOW : LEVEL_MID);
      axi_read(OSC_CONTROL_OFFSET);
      check("control", rd, 32'h0000_0038);
      axi_read(OSC_STATUS_OFFSET);
      check("status", rd, 32'h0000_0000);
    end
  endtask : t_failsafe
  task automatic t_crystal();
    cfg_type c;
    c = '0;
    c.clockSource = MODE_HIGH_XTAL;
    c.powerupDelayEn = 1'b1;
    do_reset(c);
    pinRun <= 1'b1;
    wait_edges(200);
    check("cpuRun", ctlOut.cpuRun, 1'b0);
    check("ampGain", ctlOut.ampGain, LEVEL_HIGH);
    // release the delay mid half-period so no edge straddles the start of the count
    @(negedge oscInputPin);
    @(posedge clk_sys);
    powerupDone <= 1'b1;
    wait_edges(1024);
    check("cpuRun", ctlOut.cpuRun, 1'b0);
    repeat (6) @(negedge clk_sys);
    check("cpuRun", ctlOut.cpuRun, 1'b1);
    check("startupStatus", ctlOut.startupStatus, 1'b1);
    pinRun <= 1'b0;
    repeat (10) @(posedge clk_sys);
    wakeFromSleep <= 1'b1;
    @(posedge clk_sys);
    wakeFromSleep <= 1'b0;
    repeat (100) @(negedge clk_sys);
    check("cpuRun", ctlOut.cpuRun, 1'b0);
    @(posedge clk_sys);
    pinRun <= 1'b1;
    wait_edges(1024);
    repeat (6) @(negedge clk_sys);
    check("cpuRun", ctlOut.cpuRun, 1'b1);
  endtask : t_crystal
  initial begin
    t_outside_clock();
    t_internal();
    t_failsafe();
    t_crystal();
    test_done();
  end
endmodule : testbench
